// file: lane_frame_consts.svh
// Named constants for the mode 0 lane frame mapper.
// Assumes it is included by its bare name from the package and the design file.
`ifndef LANE_FRAME_CONSTS_SVH
`define LANE_FRAME_CONSTS_SVH

`define MODE_ZERO 4'h0
`define LANE_COUNT 8
`define SAMPLE_BITS 9
`define SAMPLES_PER_FRAME 10
`define SAMPLES_PER_LANE 5
`define SLOT_BITS 12
`define PAD_ZERO 3'h0
`define TAIL_ZERO 4'h0
`define LANE_FRAME_BITS 64
`define FIFO_DEPTH 4
`define MAX_CHANNELS 4

`endif

// file: lane_frame_pkg.sv
// Types shared by the mode 0 lane frame mapper.
// Assumes lane_frame_consts.svh sits in the same folder.
`include "lane_frame_consts.svh"

package lane_frame_pkg;

	typedef logic [`SAMPLE_BITS-1:0] sample_t;

	// One frame of converter output: ten samples for each of up to four channels.
	typedef struct packed {
		sample_t [`MAX_CHANNELS-1:0][`SAMPLES_PER_FRAME-1:0] chan;
	} frame_t;

	typedef logic [`LANE_FRAME_BITS-1:0] lane_word_t;

	typedef struct packed {
		lane_word_t [`LANE_COUNT-1:0] lane;
	} lanes_t;

endpackage

// file: lane_frame_mapper_mode0.sv
// Mode 0 transport-layer formatter and its input FIFO.
// Assumes converter frames arrive on clk_sys and the link layer takes lane frames on clk_sys.
//
// What this block does
// - Mode 0: 9-bit samples on 8/4/2 lanes.
// - Lane 2 carries channel B even samples.
// - Lane 3 carries channel B odd samples, tail.
// - Lane 7 carries channel D odd samples.
// - Every tail bit is driven zero.
// - Sample MSB first, zero padding low.
// - Lowest lanes used, the rest powered down.
`timescale 1ns/1ps
`include "lane_frame_consts.svh"

module frame_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Fill side
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	// Drain side
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [CW-1:0] count;

	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	wire [CW-1:0] next_count = count + CW'(push) - CW'(pop);
	wire [AW-1:0] next_wr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
	wire [AW-1:0] next_rd = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);

	assign out_data = mem[rd_ptr];

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			wr_ptr <= push ? next_wr : wr_ptr;
			rd_ptr <= pop ? next_rd : rd_ptr;
			count <= next_count;
			in_ready <= next_count != CW'(DEPTH);
			out_valid <= next_count != '0;
		end
	end
endmodule

module lane_frame_mapper_mode0
	import lane_frame_pkg::*;
#(
	parameter int CHANNELS = 4
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Link mode selector pins
	input wire logic [3:0] link_mode_select,
	// Converter frames
	input frame_t sample_frame,
	input wire logic sample_valid,
	output logic sample_ready,
	// Lane frames toward the link layer
	output lanes_t lane_data,
	output logic lane_valid,
	input wire logic lane_ready,
	output logic [`LANE_COUNT-1:0] lane_power
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Five samples of one parity, each as nine bits then three zeros, then the tail.
	function automatic lane_word_t pack_lane(input frame_t f, input int ch, input int odd);
		lane_word_t w;
		w = '0;
		for (int s = 0; s < `SAMPLES_PER_LANE; s++) begin
			w[`LANE_FRAME_BITS-1-s*`SLOT_BITS -: `SLOT_BITS] =
				{f.chan[ch][2*s+odd], `PAD_ZERO};
		end
		w[3:0] = `TAIL_ZERO;
		return w;
	endfunction

	function automatic logic [`LANE_COUNT-1:0] used_lanes(input int nch);
		logic [`LANE_COUNT-1:0] m;
		m = '0;
		for (int i = 0; i < `LANE_COUNT; i++) begin
			m[i] = (i < 2 * nch);
		end
		return m;
	endfunction

	localparam logic [`LANE_COUNT-1:0] USED = used_lanes(CHANNELS);

	// ----------------------------------------------------------------
	// Mode selector synchroniser
	// ----------------------------------------------------------------

	logic [3:0] mode_meta;
	logic [3:0] mode_sync;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			mode_meta <= '0;
			mode_sync <= '0;
		end else begin
			mode_meta <= link_mode_select;
			mode_sync <= mode_meta;
		end
	end

	wire mode0 = (mode_sync == `MODE_ZERO);

	// ----------------------------------------------------------------
	// Input FIFO
	// ----------------------------------------------------------------

	frame_t fifo_data;
	logic fifo_valid;
	wire fifo_ready = mode0 && (!lane_valid || lane_ready);
	wire take = fifo_valid && fifo_ready;

	frame_fifo #(.WIDTH($bits(frame_t)), .DEPTH(`FIFO_DEPTH)) u_fifo (
		.clk_sys(clk_sys),
		.rst(rst),
		.in_data(sample_frame),
		.in_valid(sample_valid),
		.in_ready(sample_ready),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_ready)
	);

	// ----------------------------------------------------------------
	// Lane mapping
	// ----------------------------------------------------------------

	lanes_t next_lanes;

	always_comb begin
		next_lanes = '0;
		for (int i = 0; i < `LANE_COUNT; i++) begin
			if (USED[i]) begin
				next_lanes.lane[i] = pack_lane(fifo_data, i / 2, i % 2);
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			lane_data <= '0;
			lane_valid <= 1'b0;
			lane_power <= '0;
		end else begin
			lane_power <= mode0 ? USED : '0;
			if (!mode0) begin
				lane_valid <= 1'b0;
				lane_data <= '0;
			end else if (take) begin
				lane_valid <= 1'b1;
				lane_data <= next_lanes;
			end else if (lane_ready) begin
				lane_valid <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------

	mode_gates_lanes_a: assert property (@(posedge clk_sys) disable iff (rst)
		!mode0 |=> !lane_valid && lane_power == '0 && lane_data == '0)
		else $error("lanes active outside mode 0");

	lane_two_map_a: assert property (@(posedge clk_sys) disable iff (rst)
		take && CHANNELS >= 2 |=> lane_data.lane[2][63:55] == $past(fifo_data.chan[1][0])
			&& lane_data.lane[2][15:7] == $past(fifo_data.chan[1][8]))
		else $error("lane 2 does not hold channel B even samples");

	lane_three_map_a: assert property (@(posedge clk_sys) disable iff (rst)
		take && CHANNELS >= 2 |=> lane_data.lane[3][51:43] == $past(fifo_data.chan[1][3])
			&& lane_data.lane[3][15:7] == $past(fifo_data.chan[1][9]))
		else $error("lane 3 does not hold channel B odd samples");

	lane_seven_map_a: assert property (@(posedge clk_sys) disable iff (rst)
		take && CHANNELS == 4 |=> lane_data.lane[7][63:55] == $past(fifo_data.chan[3][1])
			&& lane_data.lane[7][39:31] == $past(fifo_data.chan[3][5]))
		else $error("lane 7 does not hold channel D odd samples");

	lane_zero_one_a: assert property (@(posedge clk_sys) disable iff (rst)
		take |=> lane_data.lane[0][27:19] == $past(fifo_data.chan[0][6])
			&& lane_data.lane[1][27:19] == $past(fifo_data.chan[0][7]))
		else $error("channel A misplaced on lanes 0 and 1");

	tail_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
		lane_valid |-> lane_data.lane[0][3:0] == 4'h0 && lane_data.lane[1][3:0] == 4'h0
			&& lane_data.lane[`LANE_COUNT-1][3:0] == 4'h0)
		else $error("tail nibble not zero");

	pad_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
		lane_valid |-> lane_data.lane[0][54:52] == 3'h0 && lane_data.lane[1][6:4] == 3'h0)
		else $error("pad bits not zero");

	unused_lanes_off_a: assert property (@(posedge clk_sys) disable iff (rst)
		take |=> lane_power == USED && (CHANNELS == 4 || lane_data.lane[`LANE_COUNT-1] == '0)
			&& (CHANNELS > 1 || lane_data.lane[2] == '0))
		else $error("unused lanes not powered down");

	lane_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
		lane_valid && !lane_ready && mode0 |=> lane_valid && $stable(lane_data))
		else $error("lane frame dropped under back-pressure");
endmodule

// file: lane_sink.sv
// Link-layer receiver model that takes lane frames from the mapper.
// Assumes the bench drives stall at the falling edge and reads got hierarchically.
`timescale 1ns/1ps

module lane_sink
	import lane_frame_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Bench control
	input wire logic stall,
	// Lane frames
	input lanes_t lane_data,
	input wire logic lane_valid,
	output logic lane_ready
);
	lanes_t got[$];

	assign lane_ready = !stall;

	// All eight lanes are taken, so the lowest lanes are always connected.
	always @(posedge clk_sys) begin
		if (!rst && lane_valid && lane_ready) begin
			got.push_back(lane_data);
		end
	end
endmodule

// file: lane_frame_mapper_mode0_bench.sv
// Self-checking bench for the mode 0 lane frame mapper with four and with two channels.
// Assumes lane_sink stands for the link layer on the lane side.
`timescale 1ns/1ps

module lane_frame_mapper_mode0_bench;
	import lane_frame_pkg::*;
	logic clk_sys, rst, sample_valid, sample_ready, stall, lane_valid, lane_ready;
	logic [3:0] link_mode_select;
	logic [7:0] lane_power;
	frame_t sample_frame;
	lanes_t lane_data;
	int n_errors, tests_run, cycles;
	frame_t sent[$];
	logic dual_ready, dual_valid;
	logic [7:0] dual_power;
	lanes_t dual_data;

	lane_frame_mapper_mode0 #(.CHANNELS(4)) DUT (.clk_sys(clk_sys), .rst(rst),
		.link_mode_select(link_mode_select), .sample_frame(sample_frame),
		.sample_valid(sample_valid), .sample_ready(sample_ready), .lane_data(lane_data),
		.lane_valid(lane_valid), .lane_ready(lane_ready), .lane_power(lane_power));
	// Two-channel build beside the quad one; it sees the same stimulus and back-pressure.
	lane_frame_mapper_mode0 #(.CHANNELS(2)) dut_dual (.clk_sys(clk_sys), .rst(rst),
		.link_mode_select(link_mode_select), .sample_frame(sample_frame),
		.sample_valid(sample_valid), .sample_ready(dual_ready), .lane_data(dual_data),
		.lane_valid(dual_valid), .lane_ready(lane_ready), .lane_power(dual_power));
	lane_sink sink (.clk_sys(clk_sys), .rst(rst), .stall(stall), .lane_data(lane_data),
		.lane_valid(lane_valid), .lane_ready(lane_ready));

	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function frame_t mk(int n);
		frame_t f;
		for (int c = 0; c < 4; c++)
			for (int s = 0; s < 10; s++)
				f.chan[c][s] = 9'(n * 97 + c * 41 + s * 53 + 256);
		return f;
	endfunction

	// Lane 2c holds even samples of channel c, lane 2c+1 the odd ones, tail left zero.
	function lanes_t exp_of(frame_t f);
		lanes_t e;
		e = '0;
		for (int i = 0; i < 8; i++)
			for (int k = 0; k < 5; k++)
				e.lane[i][63-12*k -: 12] = {f.chan[i/2][2*k+i%2], 3'h0};
		return e;
	endfunction

	// Two channels use lanes 0 to 3 only; the upper four stay zero.
	function lanes_t exp_dual(frame_t f);
		lanes_t e;
		e = exp_of(f);
		for (int i = 4; i < 8; i++)
			e.lane[i] = '0;
		return e;
	endfunction

	task chk(logic [511:0] seen, logic [511:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task conclude();
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 4000) begin
			n_errors++;
			conclude();
		end
	end

	// Entered at a falling edge; returns at the falling edge after the frame is taken.
	task send(frame_t f);
		sample_frame = f;
		sample_valid = 1'b1;
		for (int n = 0; n < 50 && !sample_ready; n++) @(negedge clk_sys);
		@(negedge clk_sys);
		sent.push_back(f);
	endtask

	task drain_cmp();
		for (int n = 0; n < 100 && sink.got.size() < sent.size(); n++) @(negedge clk_sys);
		chk(sink.got.size(), sent.size());
		while (sent.size() && sink.got.size())
			chk(sink.got.pop_front(), exp_of(sent.pop_front()));
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_map();
		for (int k = 0; k < 4; k++) send(mk(k));
		sample_valid = 1'b0;
		drain_cmp();
		chk(lane_power, 8'hff);
		chk(dual_power, 8'h0f);
	endtask

	task t_fill();
		int k;
		stall = 1'b1;
		for (k = 0; k < 8 && sample_ready; k++) send(mk(10 + k));
		sample_valid = 1'b0;
		chk(k >= 4, 1'b1);
		chk(lane_valid, 1'b1);
		chk(lane_data, exp_of(sent[0]));
		chk(dual_ready, sample_ready);
		chk(dual_valid, 1'b1);
		chk(dual_data, exp_dual(sent[0]));
		stall = 1'b0;
		drain_cmp();
	endtask

	task t_mode();
		link_mode_select = 4'h1;
		repeat (5) @(negedge clk_sys);
		chk(lane_power, 8'h00);
		chk(dual_power, 8'h00);
		send(mk(30));
		sample_valid = 1'b0;
		repeat (5) @(negedge clk_sys);
		chk(lane_valid, 1'b0);
		link_mode_select = 4'h0;
		drain_cmp();
		chk(lane_power, 8'hff);
	endtask

	initial begin
		rst = 1'b1;
		sample_valid = 1'b0;
		sample_frame = '0;
		stall = 1'b0;
		link_mode_select = 4'h0;
		n_errors = 0;
		tests_run = 0;
		cycles = 0;
		repeat (12) @(posedge clk_sys);
		@(negedge clk_sys);
		rst = 1'b0;
		repeat (4) @(negedge clk_sys);
		t_map();
		t_fill();
		t_mode();
		conclude();
	end
endmodule
